// *** src/lane_align_deskew.sv ***
`timescale 1ns/1ps
// Functional notes
// - crossbar selects physical source per logical lane
// - sysref resets local multiframe counter
// - release delay counts from multiframe edge
// - release once, at first release point after all lanes arrived
// - arrival time from modulo-64 quad-byte counter
// - sysref aligns arrival reference counter
// - buffer depth 16, or 8 when k*f=32
// - same-cycle write at read is no overflow
// - without sysref, release just after latest lane
// - overflow flags error, resets alignment state, buffer pointers and output fifo
module lane_align_deskew
  import lane_align_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic sysref,
  input wire logic subclass0,
  input wire logic [NUM_LANES-1:0] lane_enable,
  input wire logic [NUM_LANES*LANE_SEL_W-1:0] lane_select,
  input wire logic [REF_W-1:0] release_buffer_delay,
  input wire logic [REF_W-1:0] multiframe_len,
  input wire logic [7:0] k_times_f,
  input wire lane_word_s [NUM_LANES-1:0] phy_in,
  output lane_word_s [NUM_LANES-1:0] lane_out,
  output logic out_valid,
  input wire logic out_ready,
  output logic [NUM_LANES*REF_W-1:0] lane_arrival_time,
  output logic buffer_overflow_error,
  output logic link_reset,
  output logic released
);
  // ************************************************************
  // input sync and multiframe timing
  // ************************************************************
  logic sysref_m_r;
  logic sysref_s_r;
  logic sysref_d_r;
  always_ff @(posedge clock) begin
    if (rst) begin
      sysref_m_r <= 1'b0;
      sysref_s_r <= 1'b0;
      sysref_d_r <= 1'b0;
    end else begin
      sysref_m_r <= sysref;
      sysref_s_r <= sysref_m_r;
      sysref_d_r <= sysref_s_r;
    end
  end
  wire sysref_evt = sysref_s_r && !sysref_d_r && !subclass0;

  logic [REF_W-1:0] lmfc_r;
  logic [REF_W-1:0] lmfc_nxt;
  wire lmfc_wrap = (lmfc_r == multiframe_len);
  // sysref resets counter; free-running phase otherwise
  assign lmfc_nxt = sysref_evt ? REF_RESET : (lmfc_wrap ? REF_RESET : lmfc_r + 1'b1);
  always_ff @(posedge clock) begin
    if (rst) lmfc_r <= REF_RESET;
    else lmfc_r <= lmfc_nxt;
  end
  // release delay measured from multiframe edge
  wire release_point = (lmfc_r == release_buffer_delay);

  // ************************************************************
  // crossbar and elastic buffers
  // ************************************************************
  lane_word_s [NUM_LANES-1:0] xbar;
  always_comb begin
    for (int i = 0; i < NUM_LANES; i++) begin
      xbar[i] = phy_in[lane_select[i*LANE_SEL_W +: LANE_SEL_W]];
    end
  end

  // depth shrinks to 8 when k*f equals 32
  wire [EB_AW:0] eb_depth = (k_times_f == KF_SMALL) ? EB_DEPTH_SMALL[EB_AW:0]
                                                    : EB_DEPTH_MAX[EB_AW:0];

  // fill level; pointers carry one extra bit so full and empty differ
  function automatic logic [EB_AW:0] eb_level(
    input logic [EB_AW:0] wp,
    input logic [EB_AW:0] rp
  );
    return wp - rp;
  endfunction

  align_state_e state_r;
  align_state_e state_nxt;
  logic [WORD_W-1:0] eb_mem [NUM_LANES][EB_DEPTH_MAX];
  logic [EB_AW:0] wp_r [NUM_LANES];
  logic [EB_AW:0] rp_r [NUM_LANES];
  logic [REF_W-1:0] ref_r [NUM_LANES];
  logic [NUM_LANES-1:0] arrived_r;
  logic [NUM_LANES-1:0] ovf;
  logic [REF_W-1:0] arr_r [NUM_LANES];
  logic link_rst_r;
  logic err_r;
  logic rel_r;
  logic fifo_ready;
  wire reading = (state_r == ST_RUN) && fifo_ready;

  wire all_arrived = ((arrived_r & lane_enable) == lane_enable) && (lane_enable != '0);
  // release opportunity each multiframe, only when all arrived
  // subclass 0 releases right after the latest lane starts
  wire go = (state_r == ST_FILL) && all_arrived && (subclass0 || release_point);
  wire realign = sysref_evt || link_rst_r;
  // pointers and arrival flags restart on realignment and in idle
  wire ptr_clear = realign || (state_r == ST_IDLE);
  logic [NUM_LANES-1:0] lane_hit;
  logic [NUM_LANES-1:0] lane_wr;
  logic [NUM_LANES-1:0] first_wr;

  always_comb begin
    for (int i = 0; i < NUM_LANES; i++) begin
      lane_hit[i] = lane_enable[i] && xbar[i].valid;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_LANES; i++) begin
      // a write on the entry being read is not overflow
      // realign cycle excluded: pointers clear on that edge, one pulse only
      ovf[i] = lane_hit[i] && arrived_r[i] && !realign &&
               (eb_level(wp_r[i], rp_r[i]) == eb_depth) && !reading;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_LANES; i++) begin
      // an overflow word is dropped, not written
      lane_wr[i] = lane_hit[i] && !ovf[i];
      first_wr[i] = !arrived_r[i] && lane_hit[i] && (state_r == ST_FILL) && !realign;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: state_nxt = ST_FILL;
      ST_FILL: if (go) state_nxt = ST_RUN;
      ST_RUN: state_nxt = ST_RUN;
      default: state_nxt = ST_IDLE;
    endcase
    if (realign) state_nxt = ST_IDLE;
  end

  always_ff @(posedge clock) begin
    if (rst) state_r <= ST_IDLE;
    else state_r <= state_nxt;
  end

  // overflow on a used lane resets the link
  wire any_ovf = |ovf;
  always_ff @(posedge clock) begin
    if (rst) begin
      link_rst_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      link_rst_r <= any_ovf;
      // sticky until reset so a past overflow stays visible
      err_r <= err_r || any_ovf;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) rel_r <= 1'b0;
    else rel_r <= (state_nxt == ST_RUN);
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < NUM_LANES; i++) begin
      if (rst || ptr_clear) arrived_r[i] <= 1'b0;
      else if (lane_hit[i]) arrived_r[i] <= 1'b1;
    end
  end

  // ************************************************************
  // per-lane counters, arrival capture, buffer pointers
  // ************************************************************
  always_ff @(posedge clock) begin
    for (int i = 0; i < NUM_LANES; i++) begin
      if (rst || ptr_clear) wp_r[i] <= '0;
      else if (lane_wr[i]) wp_r[i] <= wp_r[i] + 1'b1;
    end
  end

  // common read start on every lane
  always_ff @(posedge clock) begin
    for (int i = 0; i < NUM_LANES; i++) begin
      if (rst || ptr_clear) rp_r[i] <= '0;
      else if (reading) rp_r[i] <= rp_r[i] + 1'b1;
    end
  end

  // sysref aligns reference; advance per quad-byte
  // counts every word of the lane, also before release, to expose skew
  always_ff @(posedge clock) begin
    for (int i = 0; i < NUM_LANES; i++) begin
      if (rst || sysref_evt) ref_r[i] <= REF_RESET;
      else if (xbar[i].valid) ref_r[i] <= ref_r[i] + 1'b1;
    end
  end

  // capture at first write, hold till realignment
  always_ff @(posedge clock) begin
    for (int i = 0; i < NUM_LANES; i++) begin
      if (rst) arr_r[i] <= REF_RESET;
      else if (first_wr[i]) arr_r[i] <= ref_r[i];
    end
  end

  // dropped overflow words must not clobber unread entries
  always_ff @(posedge clock) begin
    for (int i = 0; i < NUM_LANES; i++) begin
      if (lane_wr[i]) eb_mem[i][wp_r[i][EB_AW-1:0]] <= xbar[i].data;
    end
  end

  // ************************************************************
  // aligned output through fifo
  // ************************************************************
  // one wide word of all lanes; fifo back-pressure stalls buffer reads
  logic [NUM_LANES*WORD_W-1:0] rd_word;
  logic [NUM_LANES*WORD_W-1:0] fifo_data;
  logic fifo_valid;
  always_comb begin
    for (int i = 0; i < NUM_LANES; i++) begin
      rd_word[i*WORD_W +: WORD_W] = lane_enable[i] ? eb_mem[i][rp_r[i][EB_AW-1:0]] : '0;
    end
  end

  sync_fifo #(
    .WIDTH(NUM_LANES*WORD_W),
    .DEPTH(OUT_FIFO_DEPTH)
  ) u_out_fifo (
    .clock(clock),
    .rst(rst || realign),
    .in_valid(state_r == ST_RUN),
    .in_ready(fifo_ready),
    .in_data(rd_word),
    .out_valid(fifo_valid),
    .out_ready(out_ready || !out_valid),
    .out_data(fifo_data)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      out_valid <= 1'b0;
      lane_out <= '0;
    end else if (out_ready || !out_valid) begin
      out_valid <= fifo_valid;
      for (int i = 0; i < NUM_LANES; i++) begin
        lane_out[i].valid <= fifo_valid && lane_enable[i];
        lane_out[i].data <= fifo_data[i*WORD_W +: WORD_W];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) lane_arrival_time <= '0;
    else begin
      for (int i = 0; i < NUM_LANES; i++) lane_arrival_time[i*REF_W +: REF_W] <= arr_r[i];
    end
  end
  assign buffer_overflow_error = err_r;
  assign link_reset = link_rst_r;
  assign released = rel_r;
endmodule

// *** src/lane_align_pkg.sv ***
package lane_align_pkg;
  localparam int NUM_LANES = 16;
  localparam int LANE_SEL_W = 4;
  localparam int WORD_W = 32;
  localparam int REF_W = 6;
  localparam int EB_DEPTH_MAX = 16;
  localparam int EB_DEPTH_SMALL = 8;
  localparam int EB_AW = 4;
  localparam logic [7:0] KF_SMALL = 8'h20;
  localparam logic [REF_W-1:0] REF_RESET = 6'h00;
  localparam logic [REF_W-1:0] RBD_RESET = 6'h00;
  localparam int OUT_FIFO_DEPTH = 8;
  // serial pll settings for every 64b/66b row, applied by configuring software
  localparam logic [7:0] PLL_MPY_66B = 8'h21;
  localparam logic [1:0] PLL_RATE_LOW = 2'h1;
  localparam logic [1:0] PLL_RATE_HIGH = 2'h0;

  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] data;
  } lane_word_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FILL = 2'b01,
    ST_RUN = 2'b10
  } align_state_e;
endpackage

// *** src/sync_fifo.sv ***
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [AW:0] fill = wp_r - rp_r;
  assign in_ready = (fill != DEPTH[AW:0]);
  assign out_valid = (fill != '0);
  assign out_data = mem[rp_r[AW-1:0]];
  always_ff @(posedge clock) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (push) mem[wp_r[AW-1:0]] <= in_data;
  end
endmodule

// *** tb/lane_tx_model.sv ***
`timescale 1ns/1ps
// ****
// transmit lanes
// ****
module lane_tx_model
  import lane_align_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic go,
  input wire logic [NUM_LANES*8-1:0] lane_delay,
  output lane_word_s [NUM_LANES-1:0] phy_in
);
  logic [23:0] cnt_r;
  always_ff @(posedge clock) cnt_r <= rst ? 24'h0 : cnt_r + 24'(go);
  always_comb begin
    for (int l = 0; l < NUM_LANES; l++) begin
      phy_in[l].valid = go && cnt_r >= 24'(lane_delay[l*8+:8]);
      phy_in[l].data = {8'(l), cnt_r - 24'(lane_delay[l*8+:8])};
      if (!phy_in[l].valid) phy_in[l].data = ~phy_in[l].data;
    end
  end
endmodule

// *** tb/lane_align_deskew_props.sv ***
`timescale 1ns/1ps
// ****
// port checks
// ****
module lane_align_deskew_props
  import lane_align_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic sysref,
  input wire logic out_ready,
  input wire lane_word_s [NUM_LANES-1:0] lane_out,
  input wire logic out_valid,
  input wire logic [NUM_LANES*REF_W-1:0] lane_arrival_time,
  input wire logic buffer_overflow_error,
  input wire logic link_reset,
  input wire logic released
);
  logic [3:0] since_r;
  always_ff @(posedge clock) begin
    if (rst || sysref || link_reset) since_r <= 4'h0;
    else if (since_r != 4'hF) since_r <= since_r + 4'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  reset_clears_a:
    assert property (disable iff (1'b0) rst |=> !released && !out_valid) else $error("not reset");
  err_sticky_a:
    assert property (buffer_overflow_error |=> buffer_overflow_error) else $error("error lost");
  reset_pulse_a:
    assert property (link_reset |=> !link_reset) else $error("reset held");
  reset_cause_a:
    assert property ($rose(link_reset) |-> ##[0:2] buffer_overflow_error) else $error("no error");
  release_hold_a:
    assert property ($fell(released) |-> since_r < 4'h8) else $error("release lost");
  first_word_a:
    assert property ($rose(released) |-> ##[1:4] out_valid) else $error("no word");
  stall_hold_a:
    assert property (out_valid && !out_ready |=> $stable(lane_out)) else $error("word moved");
  arrival_hold_a:
    assert property (released && $past(released) |-> $stable(lane_arrival_time))
      else $error("arrival moved");
endmodule
bind lane_align_deskew lane_align_deskew_props lane_align_deskew_props_inst (.*);

// *** tb/tb_lane_align_deskew.sv ***
`timescale 1ns/1ps
// ****
// deskew bench
// ****
module tb_lane_align_deskew
  import lane_align_pkg::*;
;
  logic clock = 0, rst = 1, sysref = 0, subclass0 = 0, out_ready = 1, go = 0;
  logic [NUM_LANES-1:0] lane_enable = '1;
  logic [NUM_LANES*LANE_SEL_W-1:0] lane_select = '0;
  logic [REF_W-1:0] release_buffer_delay = '0, multiframe_len = 6'h03;
  logic [7:0] k_times_f = 8'h40;
  logic [NUM_LANES*8-1:0] lane_delay = '0;
  lane_word_s [NUM_LANES-1:0] phy_in, lane_out;
  logic out_valid, buffer_overflow_error, link_reset, released;
  logic [NUM_LANES*REF_W-1:0] lane_arrival_time;
  int miscompares = 0, n_compared = 0, n, off;
  always #5 clock = ~clock;
  lane_tx_model lane_tx_model_inst (.*);
  lane_align_deskew lane_align_deskew_inst (.*);
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic compare_word(string what, logic [32:0] exp, logic [32:0] got);
    n_compared++;
    if (got !== exp) miscompares++;
    if (got !== exp) $display("mismatch %s exp %h got %h", what, exp, got);
  endtask
  task automatic run_test(int t);
    @(posedge clock);
    rst <= 1;
    go <= 0;
    off = $urandom_range(15);
    repeat (4) @(posedge clock);
    for (int l = 0; l < NUM_LANES; l++) begin
      lane_select[l*4+:4] <= 4'(l + off);
      lane_delay[((l + off) % 16)*8+:8] <= (l == 0) ? 8'h00 : (t == 3) ? 8'h0C : 8'($urandom_range(t + 3));
    end
    subclass0 <= (t == 1);
    k_times_f <= (t == 3) ? 8'h20 : 8'h40;
    // release fixed per test, inside window
    release_buffer_delay <= (t == 2) ? 6'h00 : 6'($urandom_range(3));
    @(posedge clock);
    rst <= 0;
    @(posedge clock);
    sysref <= (t != 1);
    repeat (3) @(posedge clock);
    sysref <= 0;
    repeat (8) @(posedge clock);
    go <= 1;
    n = 0;
    for (int i = 0; i < 400 && n < 12; i++) begin
      @(posedge clock);
      out_ready <= !(t == 2 && i > 20 && i < 27);
      #1;
      if (t == 3 && link_reset) n = 12;
      if (t != 3 && out_valid && out_ready) begin
        for (int l = 0; l < NUM_LANES; l++)
          compare_word("word", {5'h10, 4'(l + off), 24'(n)}, lane_out[l]);
        n++;
      end
    end
    if (n < 12) miscompares++;
    if (n < 12) print_verdict();
    repeat (3) @(posedge clock);
    #1;
    compare_word("error", {32'h0, t == 3}, {32'h0, buffer_overflow_error});
    if (t != 3)
      for (int l = 0; l < NUM_LANES; l++)
        compare_word("arrival", 33'h0, 33'(lane_arrival_time[l*REF_W+:REF_W]));
    $display("test %0d done", t);
  endtask
  initial begin
    void'($urandom(32'h74428749));
    compare_word("pll mult", 33'h21, 33'(PLL_MPY_66B));
    compare_word("pll rate", 33'h4, 33'({PLL_RATE_LOW, PLL_RATE_HIGH}));
    for (int t = 0; t < 4; t++) run_test(t);
    print_verdict();
  end
endmodule
